// ---- design/wer_router.sv ----
// wake event router with vectored interrupt arbitration and apb registers
// ===========================================================
module wer_router (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [wer_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic      [31:0]                prdata,
  input  wire logic [3:0]                 wake_pin,
  input  wire logic                       reset_pin_n,
  input  wire logic                       alarm_evt,
  input  wire logic                       rtc_evt,
  input  wire logic                       osc_32k_running,
  input  wire logic                       windowed_watchdog_irq,
  input  wire logic                       brownout_detector_irq,
  input  wire logic [1:0]                 can_controllers_irq,
  input  wire logic                       quad_encoder_if_irq,
  input  wire logic                       eth_evt,
  input  wire logic                       usb_ctrl_zero_evt,
  input  wire logic                       usb_ctrl_one_evt,
  input  wire logic [wer_pkg::TMR_W-1:0]  timer_outs,
  input  wire logic [wer_pkg::NUM_IRQ-1:0] periph_irq_lines,
  input  wire wer_pkg::wer_lp_mode_t      lp_mode,
  output logic                            evr_irq,
  output logic                            wake_core,
  output logic                            wake_clock_ctrl_unit,
  output wer_pkg::wer_irq_req_t           vectored_irq_ctrl_req
);
  import wer_pkg::*;

  // ===========================================================
  // helpers
  function automatic logic prio_wins(input logic [PRIO_W-1:0] p, input logic [PRIO_W-1:0] msk,
                                     input logic have, input logic [PRIO_W-1:0] best);
    // strictly above the mask; ties keep the lower line number
    prio_wins = (p > msk) && (!have || (p > best));
  endfunction : prio_wins

  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    is_reg = (a == ofs);
  endfunction : is_reg

  wer_state_t         r_ff;
  wer_state_t         nxt_r;
  logic [NUM_EVT-1:0] evt_raw;
  logic [NUM_EVT-1:0] evt_rise;
  logic [NUM_EVT-1:0] evt_act;
  logic [NUM_EVT-1:0] w1c;
  logic [NUM_IRQ-1:0] lines;
  logic [NUM_IRQ-1:0] pending;
  logic               wr;
  logic               setup;
  logic               mapped;
  logic               mem_we;
  logic [PRIO_W-1:0]  prio_rd;
  logic               deep_wake;
  logic               sleep_wake;

  // ===========================================================
  // event inputs
  always_comb begin
    evt_raw                  = '0;
    evt_raw[EV_WAKE0 +: 4]   = wake_pin;
    evt_raw[EV_RSTPIN]       = ~reset_pin_n;
    // without the slow oscillator these sources cannot be trusted
    evt_raw[EV_ALARM]        = alarm_evt & osc_32k_running;
    evt_raw[EV_RTC]          = rtc_evt & osc_32k_running;
    evt_raw[EV_WDOG]         = windowed_watchdog_irq;
    evt_raw[EV_BROWN]        = brownout_detector_irq;
    evt_raw[EV_CAN0]         = can_controllers_irq[0];
    evt_raw[EV_CAN1]         = can_controllers_irq[1];
    evt_raw[EV_QENC]         = quad_encoder_if_irq;
    evt_raw[EV_ETH]          = eth_evt;
    evt_raw[EV_USB_ZERO]     = usb_ctrl_zero_evt;
    evt_raw[EV_USB_ONE]      = usb_ctrl_one_evt;
    // several timer outputs share one flag
    evt_raw[EV_TIMER]        = |(timer_outs & r_ff.tsel);
  end

  assign evt_rise = evt_raw & ~r_ff.prev_in;
  assign evt_act  = r_ff.status & r_ff.en;

  // router output replaces its own line among the peripheral lines
  always_comb begin
    lines               = periph_irq_lines;
    lines[EVR_IRQ_LINE] = r_ff.evr_irq;
  end
  assign pending = lines & r_ff.irq_en;

  assign deep_wake  = |(evt_act & DEEP_WAKE_MASK);
  assign sleep_wake = (lp_mode == LP_SLEEP) && ((|evt_act) || (|pending));

  // ===========================================================
  // apb decode: zero wait states, read data captured in setup
  assign setup  = psel && !penable && !r_ff.pready;
  assign wr     = psel && penable && r_ff.pready && pwrite;
  assign mapped = (paddr <= OFS_PRIO_SET) && (paddr[1:0] == 2'b00);
  assign w1c    = (wr && is_reg(paddr, OFS_EVT_STAT)) ? pwdata[NUM_EVT-1:0] : '0;
  assign mem_we = wr && is_reg(paddr, OFS_PRIO_SET)
                  && (pwdata[PRIO_IDX_LSB +: IRQ_W] <= LAST_IRQ);

  wer_prio_mem u_prio_mem (
    .pclk     (pclk),
    .presetn  (presetn),
    .we       (mem_we),
    .waddr    (pwdata[PRIO_IDX_LSB +: IRQ_W]),
    .wdata    (pwdata[PRIO_W-1:0]),
    .raddr    (r_ff.scan_idx),
    .rdata_ff (prio_rd)
  );

  // ===========================================================
  // next state
  always_comb begin
    nxt_r         = r_ff;
    nxt_r.prev_in = evt_raw;
    // edge: set wins over a clear in the same cycle; level: follow
    nxt_r.status  = (r_ff.mode & ((r_ff.status & ~w1c) | evt_rise))
                    | (~r_ff.mode & evt_raw);
    nxt_r.evr_irq = |evt_act;
    nxt_r.wake    = deep_wake || sleep_wake;

    // priority sweep over all lines, one per cycle
    nxt_r.scan_idx   = (r_ff.scan_idx == LAST_IRQ) ? '0 : r_ff.scan_idx + 6'h01;
    nxt_r.scan_idx_d = r_ff.scan_idx;
    nxt_r.scan_vld   = 1'b1;
    if (r_ff.scan_vld) begin
      if (pending[r_ff.scan_idx_d] &&
          prio_wins(prio_rd, r_ff.mask, r_ff.best_vld, r_ff.best_prio)) begin
        nxt_r.best_vld  = 1'b1;
        nxt_r.best_id   = r_ff.scan_idx_d;
        nxt_r.best_prio = prio_rd;
      end
      if (r_ff.scan_idx_d == LAST_IRQ) begin
        nxt_r.res.active = nxt_r.best_vld;
        nxt_r.res.id     = nxt_r.best_id;
        nxt_r.res.prio   = nxt_r.best_prio;
        nxt_r.best_vld   = 1'b0;
        nxt_r.best_id    = '0;
        nxt_r.best_prio  = '0;
      end
    end

    // register writes
    if (wr) begin
      unique case (1'b1)
        is_reg(paddr, OFS_EVT_EN):   nxt_r.en   = pwdata[NUM_EVT-1:0];
        is_reg(paddr, OFS_EVT_MODE): nxt_r.mode = pwdata[NUM_EVT-1:0];
        is_reg(paddr, OFS_IRQ_ENLO): nxt_r.irq_en[31:0] = pwdata;
        is_reg(paddr, OFS_IRQ_ENHI): nxt_r.irq_en[NUM_IRQ-1:32] = pwdata[NUM_IRQ-33:0];
        is_reg(paddr, OFS_PRIO_MSK): nxt_r.mask = pwdata[PRIO_W-1:0];
        is_reg(paddr, OFS_TMR_SEL):  nxt_r.tsel = pwdata[TMR_W-1:0];
        default: ;
      endcase
    end

    // bus answer
    nxt_r.pready  = setup;
    nxt_r.pslverr = setup && !mapped;
    if (setup && !pwrite) begin
      nxt_r.prdata = 32'h0;
      unique case (1'b1)
        is_reg(paddr, OFS_EVT_EN):   nxt_r.prdata[NUM_EVT-1:0] = r_ff.en;
        is_reg(paddr, OFS_EVT_MODE): nxt_r.prdata[NUM_EVT-1:0] = r_ff.mode;
        is_reg(paddr, OFS_EVT_STAT): nxt_r.prdata[NUM_EVT-1:0] = r_ff.status;
        is_reg(paddr, OFS_EVT_RAW):  nxt_r.prdata[NUM_EVT-1:0] = evt_raw;
        is_reg(paddr, OFS_IRQ_ENLO): nxt_r.prdata = r_ff.irq_en[31:0];
        is_reg(paddr, OFS_IRQ_ENHI): nxt_r.prdata[NUM_IRQ-33:0] = r_ff.irq_en[NUM_IRQ-1:32];
        is_reg(paddr, OFS_PRIO_MSK): nxt_r.prdata[PRIO_W-1:0] = r_ff.mask;
        is_reg(paddr, OFS_TMR_SEL):  nxt_r.prdata[TMR_W-1:0] = r_ff.tsel;
        is_reg(paddr, OFS_PRIO_SET): begin
          nxt_r.prdata[ARB_ACT_BIT]               = r_ff.res.active;
          nxt_r.prdata[PRIO_IDX_LSB +: IRQ_W]     = r_ff.res.id;
          nxt_r.prdata[PRIO_W-1:0]                = r_ff.res.prio;
        end
        default: ;
      endcase
    end else if (setup) begin
      nxt_r.prdata = 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff        <= '0;
      r_ff.en     <= RST_EVT_EN;
      r_ff.mode   <= RST_EVT_MODE;
      r_ff.irq_en <= RST_IRQ_EN;
      r_ff.mask   <= RST_PRIO_MSK;
      r_ff.tsel   <= RST_TMR_SEL;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ===========================================================
  // outputs
  assign pready                = r_ff.pready;
  assign pslverr               = r_ff.pslverr;
  assign prdata                = r_ff.prdata;
  assign evr_irq               = r_ff.evr_irq;
  assign wake_core             = r_ff.wake;
  assign wake_clock_ctrl_unit  = r_ff.wake;
  assign vectored_irq_ctrl_req = r_ff.res;

  // ===========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_disabled_quiet;
    (r_ff.en == 16'h0000) [*2] |-> !r_ff.evr_irq;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled events raised irq");

  property p_edge_latch;
    r_ff.mode[0] && evt_raw[0] && !r_ff.prev_in[0] |=> r_ff.status[0];
  endproperty
  a_edge_latch: assert property (p_edge_latch) else $error("edge event not latched");

  property p_edge_hold;
    r_ff.mode[0] && $stable(r_ff.mode) && r_ff.status[0] && !w1c[0] |=> r_ff.status[0];
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge event lost without clear");

  property p_level_follow;
    !r_ff.mode[1] |=> r_ff.status[1] == $past(evt_raw[1]);
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("level event not following");

  property p_no_deep_wake;
    (lp_mode != LP_SLEEP) && ((evt_act & DEEP_WAKE_MASK) == 16'h0000) |=> !wake_core;
  endproperty
  a_no_deep_wake: assert property (p_no_deep_wake) else $error("sleep-only event woke deep mode");

  property p_osc_gate;
    !osc_32k_running && !r_ff.mode[EV_RTC] |=> !r_ff.status[EV_RTC];
  endproperty
  a_osc_gate: assert property (p_osc_gate) else $error("rtc event without oscillator");

  property p_irq_wakes_sleep;
    (lp_mode == LP_SLEEP) && (|pending) |=> wake_core && wake_clock_ctrl_unit;
  endproperty
  a_irq_wakes_sleep: assert property (p_irq_wakes_sleep) else $error("enabled irq did not wake");

  // any active enabled flag must show on the router's single line next cycle
  property p_line_carries;
    |(r_ff.status & r_ff.en) |=> evr_irq && lines[EVR_IRQ_LINE];
  endproperty
  a_line_carries: assert property (p_line_carries) else $error("router line not driven");

  property p_scan_range;
    r_ff.scan_idx == LAST_IRQ |=> r_ff.scan_idx == 6'h00;
  endproperty
  a_scan_range: assert property (p_scan_range) else $error("sweep passed last line");

  property p_mask_floor;
    r_ff.res.active |-> r_ff.res.prio != 3'h0;
  endproperty
  a_mask_floor: assert property (p_mask_floor) else $error("level zero passed the mask");

endmodule : wer_router

// ---- design/wer_pkg.sv ----
// shared constants and types for the wake event router
package wer_pkg;

  // ===========================================================
  // sizes
  localparam int NUM_EVT   = 16;
  localparam int NUM_IRQ   = 53;
  localparam int PRIO_W    = 3;
  localparam int IRQ_W     = 6;
  localparam int TMR_W     = 4;
  localparam int ADDR_W    = 12;

  // ===========================================================
  // event bit positions
  localparam int EV_WAKE0  = 0;
  localparam int EV_RSTPIN = 4;
  localparam int EV_ALARM  = 5;
  localparam int EV_RTC    = 6;
  localparam int EV_WDOG   = 7;
  localparam int EV_BROWN  = 8;
  localparam int EV_CAN0   = 9;
  localparam int EV_CAN1   = 10;
  localparam int EV_QENC   = 11;
  localparam int EV_ETH    = 12;
  localparam int EV_USB_ZERO = 13;
  localparam int EV_USB_ONE  = 14;
  localparam int EV_TIMER  = 15;

  // events allowed to wake from the deeper modes
  localparam logic [NUM_EVT-1:0] DEEP_WAKE_MASK = 16'h007F;
  // line of the vectored controller that carries this router
  localparam logic [IRQ_W-1:0]   EVR_IRQ_LINE   = 6'h2A;
  localparam logic [IRQ_W-1:0]   LAST_IRQ       = 6'h34;

  // ===========================================================
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_EVT_EN   = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_EVT_MODE = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_EVT_RAW  = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENLO = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENHI = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_PRIO_MSK = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_TMR_SEL  = 12'h01C;
  localparam logic [ADDR_W-1:0] OFS_PRIO_SET = 12'h020;

  // field positions of the priority write / arbitration read word
  localparam int PRIO_IDX_LSB = 8;
  localparam int ARB_ACT_BIT  = 31;

  // reset values
  localparam logic [NUM_EVT-1:0] RST_EVT_EN   = 16'h0000;
  localparam logic [NUM_EVT-1:0] RST_EVT_MODE = 16'h0000;
  localparam logic [NUM_IRQ-1:0] RST_IRQ_EN   = 53'h0;
  localparam logic [PRIO_W-1:0]  RST_PRIO_MSK = 3'h0;
  localparam logic [TMR_W-1:0]   RST_TMR_SEL  = 4'hF;

  // ===========================================================
  // types
  typedef enum logic [1:0] {
    LP_SLEEP      = 2'b00,
    LP_DEEP_SLEEP = 2'b01,
    LP_POWER_DOWN = 2'b10,
    LP_DEEP_PD    = 2'b11
  } wer_lp_mode_t;

  typedef struct packed {
    logic              active;
    logic [IRQ_W-1:0]  id;
    logic [PRIO_W-1:0] prio;
  } wer_irq_req_t;

  typedef struct packed {
    logic [NUM_EVT-1:0] en;
    logic [NUM_EVT-1:0] mode;
    logic [NUM_EVT-1:0] status;
    logic [NUM_EVT-1:0] prev_in;
    logic [NUM_IRQ-1:0] irq_en;
    logic [PRIO_W-1:0]  mask;
    logic [TMR_W-1:0]   tsel;
    logic [IRQ_W-1:0]   scan_idx;
    logic [IRQ_W-1:0]   scan_idx_d;
    logic               scan_vld;
    logic               best_vld;
    logic [IRQ_W-1:0]   best_id;
    logic [PRIO_W-1:0]  best_prio;
    wer_irq_req_t       res;
    logic               evr_irq;
    logic               wake;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
  } wer_state_t;

endpackage : wer_pkg

// ---- design/wer_prio_mem.sv ----
// priority storage for the vectored interrupt lines, registered read
module wer_prio_mem (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      we,
  input  wire logic [wer_pkg::IRQ_W-1:0]  waddr,
  input  wire logic [wer_pkg::PRIO_W-1:0] wdata,
  input  wire logic [wer_pkg::IRQ_W-1:0]  raddr,
  output logic      [wer_pkg::PRIO_W-1:0] rdata_ff
);
  import wer_pkg::*;

  // ===========================================================
  // storage; no reset on the array, priorities are software setup
  logic [PRIO_W-1:0] mem [NUM_IRQ];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 3'h0;
    end else begin
      rdata_ff <= mem[raddr];
    end
  end

endmodule : wer_prio_mem

// ---- test/wer_core_model.sv ----
// model of the core and clock control side that consumes the wake outputs
module wer_core_model
  import wer_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire wer_pkg::wer_lp_mode_t mode_req,
  input  wire logic                  wake_core,
  input  wire logic                  wake_clock_ctrl_unit,
  output wer_pkg::wer_lp_mode_t      lp_mode,
  output logic                       woke_ff,
  output logic                       split_ff
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========
  // power state and wake capture
  // a wake seen by only one of the two units would leave core and clocks out of step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_mode  <= LP_SLEEP;
      woke_ff  <= 1'b0;
      split_ff <= 1'b0;
    end else begin
      lp_mode  <= mode_req;
      woke_ff  <= woke_ff | (wake_core & wake_clock_ctrl_unit);
      split_ff <= split_ff | (wake_core ^ wake_clock_ctrl_unit);
    end
  end
endmodule : wer_core_model

// ---- test/wake_event_router_test.sv ----
// self-checking bench for the wake event router
module wake_event_router_test;
  timeunit 1ns;
  timeprecision 100ps;
  import wer_pkg::*;

  // ==========
  // signals
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [ADDR_W-1:0]  paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic [NUM_EVT-1:0] ev;
  logic               osc;
  logic [TMR_W-1:0]   tmr;
  logic [NUM_IRQ-1:0] lines;
  wer_lp_mode_t       mode_req;
  wer_lp_mode_t       lp_mode;
  logic               evr_irq;
  logic               wake_core;
  logic               wake_clkctl;
  logic               woke;
  logic               split;
  wer_irq_req_t       req;
  logic [31:0]        rd;
  logic               err;
  int                 miscompares;
  int                 checks_done;

  localparam logic [ADDR_W-1:0] RST_OFS [6] = '{OFS_EVT_EN, OFS_EVT_MODE, OFS_IRQ_ENLO,
                                                OFS_IRQ_ENHI, OFS_PRIO_MSK, OFS_TMR_SEL};
  localparam logic [31:0]       RST_VAL [6] = '{32'(RST_EVT_EN), 32'(RST_EVT_MODE), 32'(RST_IRQ_EN[31:0]),
                                                32'(RST_IRQ_EN[NUM_IRQ-1:32]), 32'(RST_PRIO_MSK),
                                                32'(RST_TMR_SEL)};

  always #5 pclk = ~pclk;

  // ==========
  // design and far side
  // timer output 3 follows the timer event bit; tmr drives the other outputs
  wer_router u_wer_router (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .wake_pin(ev[3:0]), .reset_pin_n(~ev[4]), .alarm_evt(ev[5]), .rtc_evt(ev[6]),
    .osc_32k_running(osc), .windowed_watchdog_irq(ev[7]), .brownout_detector_irq(ev[8]),
    .can_controllers_irq(ev[10:9]), .quad_encoder_if_irq(ev[11]), .eth_evt(ev[12]),
    .usb_ctrl_zero_evt(ev[13]), .usb_ctrl_one_evt(ev[14]), .timer_outs(tmr | {ev[15], 3'h0}),
    .periph_irq_lines(lines), .lp_mode(lp_mode), .evr_irq(evr_irq), .wake_core(wake_core),
    .wake_clock_ctrl_unit(wake_clkctl), .vectored_irq_ctrl_req(req)
  );

  wer_core_model u_wer_core_model (
    .pclk(pclk), .presetn(presetn), .mode_req(mode_req), .wake_core(wake_core),
    .wake_clock_ctrl_unit(wake_clkctl), .lp_mode(lp_mode), .woke_ff(woke), .split_ff(split)
  );

  // ==========
  // tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask : step

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      summarize();
    end
  endtask : apb

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  // the arbiter publishes once per sweep, so allow a few sweeps
  task automatic wait_req(input logic [9:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (req !== exp && n < 300);
    check(32'(req), 32'(exp));
    if (n >= 300) begin
      summarize();
    end
  endtask : wait_req

  // ==========
  // main sequence
  initial begin
    pclk        = 1'b0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = '0;
    pwdata      = '0;
    ev          = '0;
    tmr         = '0;
    osc         = 1'b1;
    lines       = '0;
    mode_req    = LP_SLEEP;
    miscompares = 0;
    checks_done = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (RST_OFS[k]) begin
      rdchk(RST_OFS[k], RST_VAL[k]);
    end
    apb(1'b1, 12'h003, 32'h0000FFFF);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 12'h024, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    rdchk(OFS_EVT_EN, 32'h0);
    // every event in every low-power mode, level sensitive
    apb(1'b1, OFS_EVT_EN, 32'h0000FFFF);
    for (int m = 0; m < 4; m++) begin
      @(posedge pclk);
      mode_req <= wer_lp_mode_t'(m);
      for (int i = 0; i < NUM_EVT; i++) begin
        @(posedge pclk);
        ev[i] <= 1'b1;
        step(3);
        #1 check({evr_irq, wake_core}, {1'b1, m == 0 || DEEP_WAKE_MASK[i]});
        rdchk(OFS_EVT_STAT, 32'h1 << i);
        @(posedge pclk);
        ev[i] <= 1'b0;
        step(3);
        #1 check({evr_irq, wake_core}, 2'b00);
      end
    end
    // disabled pin, stopped 32 kHz oscillator, unselected timer output
    apb(1'b1, OFS_EVT_EN, 32'h0000FFF7);
    apb(1'b1, OFS_TMR_SEL, 32'h7);
    rdchk(OFS_TMR_SEL, 32'h7);
    mode_req <= LP_SLEEP;
    osc      <= 1'b0;
    @(posedge pclk);
    ev <= 16'h8028;
    step(3);
    #1 check({evr_irq, wake_core}, 2'b00);
    // alarm is gated off without the slow oscillator, only the disabled pin shows raw
    rdchk(OFS_EVT_RAW, 32'h00000008);
    @(posedge pclk);
    ev  <= '0;
    osc <= 1'b1;
    tmr <= 4'h6;
    step(3);
    #1 check({evr_irq, wake_core}, 2'b11);
    @(posedge pclk);
    tmr <= '0;
    // edge event latches, level event follows a one-cycle pulse
    apb(1'b1, OFS_EVT_MODE, 32'h1);
    apb(1'b1, OFS_EVT_EN, 32'h3);
    ev <= 16'h0003;
    @(posedge pclk);
    ev <= '0;
    step(3);
    #1 check({evr_irq, wake_core}, 2'b11);
    rdchk(OFS_EVT_STAT, 32'h1);
    apb(1'b1, OFS_EVT_STAT, 32'h1);
    step(2);
    #1 check({evr_irq, wake_core}, 2'b00);
    // vectored lines, priorities and masking
    apb(1'b1, OFS_EVT_EN, 32'h0);
    apb(1'b1, OFS_PRIO_SET, 32'h0503);
    apb(1'b1, OFS_PRIO_SET, 32'h0A06);
    apb(1'b1, OFS_PRIO_SET, 32'h3407);
    apb(1'b1, OFS_IRQ_ENLO, 32'h00000420);
    apb(1'b1, OFS_IRQ_ENHI, 32'h00100000);
    apb(1'b1, OFS_PRIO_MSK, 32'h2);
    lines[5]  <= 1'b1;
    lines[10] <= 1'b1;
    wait_req({1'b1, 6'h0A, 3'h6});
    check({31'h0, wake_core}, 32'h1);
    rdchk(OFS_PRIO_SET, 32'h80000A06);
    mode_req <= LP_DEEP_SLEEP;
    step(3);
    #1 check({31'h0, wake_core}, 32'h0);
    apb(1'b1, OFS_PRIO_MSK, 32'h6);
    wait_req(10'h0);
    @(posedge pclk);
    lines[52] <= 1'b1;
    wait_req({1'b1, 6'h34, 3'h7});
    check({30'h0, woke, split}, 32'h2);
    summarize();
  end
endmodule : wake_event_router_test
